// >>> src/dcs_debug_ctrl.sv
// Debug control, debug status and one watchpoint comparator behind scan chain 2
`timescale 1ns/1ps
`include "dcs_defs.svh"
module dcs_debug_ctrl (
	// System clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Test clock domain and scan chain
	input  wire logic        tck,
	input  wire logic        trst_n,
	input  wire logic        tdi,
	input  wire logic        scan_sel,
	input  wire logic        tap_capture_dr,
	input  wire logic        tap_shift_dr,
	input  wire logic        tap_update_dr,
	input  wire logic        tap_run_idle,
	output logic             tdo,
	// Halt handshake
	input  wire logic        halt_request,
	input  wire logic        core_halt_ack,
	output logic             combined_halt_request_out,
	output logic             core_halt_request,
	output logic             halt_acknowledge,
	output logic             core_irq_gate,
	// Core state
	input  wire logic        compact_isa_flag,
	input  wire logic        core_memory_request_n,
	// Core bus for the comparator
	input  wire logic [31:0] core_addr,
	input  wire logic [31:0] core_data,
	input  wire logic        fetch_not_data_bit,
	input  wire logic        direction_bit,
	input  wire logic [1:0]  access_size_field,
	input  wire logic        privileged_access_bit,
	output logic             breakpoint_hit
);
	// Test clock domain state
	dcs_pkg::dcs_chain_t          sr_q;
	dcs_pkg::dcs_addr_t           rd_addr_q;
	logic [`DCS_CTRL_W-1:0]       ctrl_q;
	logic                         req_latch_q;
	dcs_pkg::dcs_word_t           wp_av_q;
	dcs_pkg::dcs_word_t           wp_am_q;
	dcs_pkg::dcs_word_t           wp_dv_q;
	dcs_pkg::dcs_word_t           wp_dm_q;
	logic [`DCS_CV_W-1:0]         wp_cv_q;
	logic [`DCS_CM_W-1:0]         wp_cm_q;
	logic                         wp_tog_q;
	logic [`DCS_STATUS_W-1:0]     st_s1_q;
	logic [`DCS_STATUS_W-1:0]     st_s2_q;

	// System clock domain state
	logic [`DCS_CTRL_W-1:0]       c_s1_q;
	logic [`DCS_CTRL_W-1:0]       c_s2_q;
	logic                         hr_s1_q;
	logic                         hr_s2_q;
	logic                         t_s1_q;
	logic                         t_s2_q;
	logic                         t_s3_q;
	dcs_pkg::dcs_word_t           sh_av_q;
	dcs_pkg::dcs_word_t           sh_am_q;
	dcs_pkg::dcs_word_t           sh_dv_q;
	dcs_pkg::dcs_word_t           sh_dm_q;
	logic [`DCS_CV_W-1:0]         sh_cv_q;
	logic [`DCS_CM_W-1:0]         sh_cm_q;
	logic [`DCS_STATUS_W-1:0]     st_src_q;
	logic                         hit_q;

	// Scan access decode
	wire                          upd = scan_sel & tap_update_dr;
	wire                          upd_wr = upd & sr_q[`DCS_RW_BIT];
	wire                          upd_rd = upd & ~sr_q[`DCS_RW_BIT];
	wire dcs_pkg::dcs_addr_t      sr_addr = sr_q[`DCS_ADDR_MSB:`DCS_ADDR_LSB];
	wire dcs_pkg::dcs_word_t      sr_data = sr_q[`DCS_DATA_MSB:0];
	wire                          wr_ctrl = upd_wr && (sr_addr == `DCS_ADDR_CTRL);
	wire                          wr_av = upd_wr && (sr_addr == `DCS_ADDR_WP_AV);
	wire                          wr_am = upd_wr && (sr_addr == `DCS_ADDR_WP_AM);
	wire                          wr_dv = upd_wr && (sr_addr == `DCS_ADDR_WP_DV);
	wire                          wr_dm = upd_wr && (sr_addr == `DCS_ADDR_WP_DM);
	wire                          wr_cv = upd_wr && (sr_addr == `DCS_ADDR_WP_CV);
	wire                          wr_cm = upd_wr && (sr_addr == `DCS_ADDR_WP_CM);
	wire                          wr_wp = wr_av | wr_am | wr_dv | wr_dm | wr_cv | wr_cm;

	// Read data, selected by the address of the last read access
	wire dcs_pkg::dcs_word_t      rd_word =
		(rd_addr_q == `DCS_ADDR_CTRL)   ? {29'h0000000, ctrl_q} :
		(rd_addr_q == `DCS_ADDR_STATUS) ? {27'h0000000, st_s2_q} :
		(rd_addr_q == `DCS_ADDR_WP_AV)  ? wp_av_q :
		(rd_addr_q == `DCS_ADDR_WP_AM)  ? wp_am_q :
		(rd_addr_q == `DCS_ADDR_WP_DV)  ? wp_dv_q :
		(rd_addr_q == `DCS_ADDR_WP_DM)  ? wp_dm_q :
		(rd_addr_q == `DCS_ADDR_WP_CV)  ? {23'h000000, wp_cv_q} :
		(rd_addr_q == `DCS_ADDR_WP_CM)  ? {24'h000000, wp_cm_q} :
		32'h00000000;

	// Scan shift register: capture loads read data, shift moves toward tdo
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			sr_q <= 38'h0000000000;
		end else if (scan_sel && tap_capture_dr) begin
			sr_q <= {sr_q[`DCS_RW_BIT:`DCS_ADDR_LSB], rd_word};
		end else if (scan_sel && tap_shift_dr) begin
			sr_q <= {tdi, sr_q[`DCS_RW_BIT:1]};
		end
	end

	assign tdo = sr_q[0];

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			rd_addr_q <= `DCS_ADDR_CTRL;
		end else if (upd_rd) begin
			rd_addr_q <= sr_addr;
		end
	end

	// Control register; status writes are accepted but its bits are live state
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ctrl_q <= `DCS_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= sr_data[`DCS_CTRL_W-1:0];
		end
	end

	// Request latch opens only in run-test-idle so several cores can be released together
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			req_latch_q <= 1'b0;
		end else if (tap_run_idle) begin
			req_latch_q <= ctrl_q[`DCS_CTRL_HALT_REQ];
		end
	end

	// Watchpoint registers
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			wp_av_q <= `DCS_WORD_RESET;
			wp_am_q <= `DCS_WORD_RESET;
			wp_dv_q <= `DCS_WORD_RESET;
			wp_dm_q <= `DCS_WORD_RESET;
			wp_cv_q <= `DCS_CV_RESET;
			wp_cm_q <= `DCS_CM_RESET;
		end else begin
			if (wr_av) wp_av_q <= sr_data;
			if (wr_am) wp_am_q <= sr_data;
			if (wr_dv) wp_dv_q <= sr_data;
			if (wr_dm) wp_dm_q <= sr_data;
			if (wr_cv) wp_cv_q <= sr_data[`DCS_CV_W-1:0];
			if (wr_cm) wp_cm_q <= sr_data[`DCS_CM_W-1:0];
		end
	end

	// Toggle announces new watchpoint contents to the system domain
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			wp_tog_q <= 1'b0;
		end else if (wr_wp) begin
			wp_tog_q <= ~wp_tog_q;
		end
	end

	// Status sampled into the test clock domain
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			st_s1_q <= 5'h00;
			st_s2_q <= 5'h00;
		end else begin
			st_s1_q <= st_src_q;
			st_s2_q <= st_s1_q;
		end
	end

	// System domain synchronisers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			c_s1_q  <= `DCS_CTRL_RESET;
			c_s2_q  <= `DCS_CTRL_RESET;
			hr_s1_q <= 1'b0;
			hr_s2_q <= 1'b0;
			t_s1_q  <= 1'b0;
			t_s2_q  <= 1'b0;
			t_s3_q  <= 1'b0;
		end else begin
			c_s1_q  <= {ctrl_q[`DCS_CTRL_IRQ_BLOCK], req_latch_q, ctrl_q[`DCS_CTRL_HALT_ACK]};
			c_s2_q  <= c_s1_q;
			hr_s1_q <= halt_request;
			hr_s2_q <= hr_s1_q;
			t_s1_q  <= wp_tog_q;
			t_s2_q  <= t_s1_q;
			t_s3_q  <= t_s2_q;
		end
	end

	wire                          wp_load = t_s2_q ^ t_s3_q;
	wire                          combined = c_s2_q[`DCS_CTRL_HALT_REQ] | hr_s2_q;

	assign combined_halt_request_out = combined;
	assign core_halt_request = combined;
	assign halt_acknowledge = core_halt_ack | c_s2_q[`DCS_CTRL_HALT_ACK];
	assign core_irq_gate = ~(halt_acknowledge | c_s2_q[`DCS_CTRL_IRQ_BLOCK]);

	// Shadow copy of the watchpoint: source words stay put for many test clocks after a write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_av_q <= `DCS_WORD_RESET;
			sh_am_q <= `DCS_WORD_RESET;
			sh_dv_q <= `DCS_WORD_RESET;
			sh_dm_q <= `DCS_WORD_RESET;
			sh_cv_q <= `DCS_CV_RESET;
			sh_cm_q <= `DCS_CM_RESET;
		end else if (wp_load) begin
			sh_av_q <= wp_av_q;
			sh_am_q <= wp_am_q;
			sh_dv_q <= wp_dv_q;
			sh_dm_q <= wp_dm_q;
			sh_cv_q <= wp_cv_q;
			sh_cm_q <= wp_cm_q;
		end
	end

	// Status source registered so the test-side synchroniser sees clean levels
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_src_q <= 5'h00;
		end else begin
			st_src_q <= {compact_isa_flag, core_memory_request_n, core_irq_gate,
				combined, halt_acknowledge};
		end
	end

	// Comparator: on a 16-bit fetch the half not carrying the opcode is masked off
	wire                          half_fetch = compact_isa_flag & ~fetch_not_data_bit;
	wire dcs_pkg::dcs_word_t      half_ign = core_addr[1] ? `DCS_IGNORE_LOW : `DCS_IGNORE_HIGH;
	wire dcs_pkg::dcs_word_t      data_mask = half_fetch ? (sh_dm_q | half_ign) : sh_dm_q;
	wire [`DCS_CM_W-1:0]          ctrl_sample = {3'h0, privileged_access_bit,
		fetch_not_data_bit, access_size_field, direction_bit};
	logic                         addr_match;
	logic                         data_match;
	logic                         ctrl_match;

	dcs_mask_cmp #(.WIDTH(32)) u_addr_cmp (
		.value  (sh_av_q),
		.mask   (sh_am_q),
		.sample (core_addr),
		.match  (addr_match)
	);

	dcs_mask_cmp #(.WIDTH(32)) u_data_cmp (
		.value  (sh_dv_q),
		.mask   (data_mask),
		.sample (core_data),
		.match  (data_match)
	);

	dcs_mask_cmp #(.WIDTH(`DCS_CM_W)) u_ctrl_cmp (
		.value  (sh_cv_q[`DCS_CM_W-1:0]),
		.mask   (sh_cm_q),
		.sample (ctrl_sample),
		.match  (ctrl_match)
	);

	wire                          hit = addr_match & data_match & ctrl_match
		& sh_cv_q[`DCS_CV_ENABLE];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= hit;
		end
	end

	assign breakpoint_hit = hit_q;

	// Test clock domain checks
	ctrl_write_a: assert property (@(posedge tck) disable iff (!trst_n)
		wr_ctrl |=> ctrl_q == $past(sr_q[2:0]))
		else $error("control write not stored");

	ctrl_keep_a: assert property (@(posedge tck) disable iff (!trst_n)
		(upd && !sr_q[`DCS_RW_BIT]) |=> $stable(ctrl_q))
		else $error("control changed on a read access");

	latch_hold_a: assert property (@(posedge tck) disable iff (!trst_n)
		!tap_run_idle |=> $stable(req_latch_q))
		else $error("request latch moved outside run-test-idle");

	latch_follow_a: assert property (@(posedge tck) disable iff (!trst_n)
		tap_run_idle |=> req_latch_q == $past(ctrl_q[1]))
		else $error("request latch missed control bit 1");

	status_read_a: assert property (@(posedge tck) disable iff (!trst_n)
		(scan_sel && tap_capture_dr && rd_addr_q == `DCS_ADDR_STATUS)
		|=> sr_q[4:0] == $past(st_s2_q) && sr_q[31:5] == 27'h0000000)
		else $error("status capture wrong");

	// System clock domain checks
	irq_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c_s2_q[2] |-> !core_irq_gate)
		else $error("interrupt gate open while blocked");

	irq_open_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		core_irq_gate |-> !halt_acknowledge && !c_s2_q[2])
		else $error("interrupt gate open during acknowledge");

	ext_req_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		halt_request [*3] |-> combined_halt_request_out && core_halt_request)
		else $error("external request not passed on");

	ack_or_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(core_halt_ack || c_s2_q[0]) |-> halt_acknowledge)
		else $error("acknowledge not ORed");

	hit_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		breakpoint_hit |-> $past(sh_cv_q[8]) && $past(addr_match))
		else $error("hit without enable or address match");

	// Main scenarios
	ctrl_wr_c: cover property (@(posedge tck) disable iff (!trst_n) wr_ctrl);
	req_rel_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(combined_halt_request_out));
	half_hit_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		half_fetch && hit);
	wp_load_c: cover property (@(posedge sys_clk) disable iff (!rst_n) wp_load);
endmodule : dcs_debug_ctrl

// >>> src/dcs_defs.svh
// Register addresses, field positions, reset values and masks of the debug control block
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

// Scan chain layout: data field, address field, read/write bit
`define DCS_CHAIN_LEN     38
`define DCS_DATA_MSB      31
`define DCS_ADDR_LSB      32
`define DCS_ADDR_MSB      36
`define DCS_RW_BIT        37

// Register addresses on the scan chain
`define DCS_ADDR_CTRL     5'h00
`define DCS_ADDR_STATUS   5'h01
`define DCS_ADDR_WP_AV    5'h08
`define DCS_ADDR_WP_AM    5'h09
`define DCS_ADDR_WP_DV    5'h0a
`define DCS_ADDR_WP_DM    5'h0b
`define DCS_ADDR_WP_CV    5'h0c
`define DCS_ADDR_WP_CM    5'h0d

// Widths of the registers
`define DCS_CTRL_W        3
`define DCS_STATUS_W      5
`define DCS_CV_W          9
`define DCS_CM_W          8

// Debug control fields
`define DCS_CTRL_IRQ_BLOCK 2
`define DCS_CTRL_HALT_REQ  1
`define DCS_CTRL_HALT_ACK  0
`define DCS_CTRL_RESET     3'h0

// Watchpoint control value: enable bit
`define DCS_CV_ENABLE      8

// Reset values of watchpoint registers
`define DCS_WORD_RESET     32'h00000000
`define DCS_CV_RESET       9'h000
`define DCS_CM_RESET       8'hff

// Data bus halves ignored on a 16-bit fetch
`define DCS_IGNORE_LOW     32'h0000ffff
`define DCS_IGNORE_HIGH    32'hffff0000

`endif

// >>> src/dcs_pkg.sv
// Types shared by the debug control and status block
package dcs_pkg;
	typedef logic [4:0]  dcs_addr_t;
	typedef logic [31:0] dcs_word_t;
	typedef logic [37:0] dcs_chain_t;
endpackage : dcs_pkg

// >>> src/dcs_mask_cmp.sv
// Masked equality comparator: a mask bit of one forces its position to match
`timescale 1ns/1ps
module dcs_mask_cmp #(
	parameter int WIDTH = 32
) (
	// Operands
	input  wire logic [WIDTH-1:0] value,
	input  wire logic [WIDTH-1:0] mask,
	input  wire logic [WIDTH-1:0] sample,
	// Result
	output logic                  match
);
	wire [WIDTH-1:0] bit_ok = (value ~^ sample) | mask;

	assign match = &bit_ok;
endmodule : dcs_mask_cmp

// >>> tb/dcs_core_model.sv
// Core-side partner: answers a halt request with an acknowledge after a fixed lag
`timescale 1ns/1ps
module dcs_core_model #(
	parameter int ACK_DLY = 3
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Halt handshake
	input  wire logic core_halt_request,
	output logic      core_halt_ack
);
	logic [ACK_DLY-1:0] dly_q;

	// A real core ends its current instruction first, so the answer lags the request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dly_q <= '0;
		end else begin
			dly_q <= {dly_q[ACK_DLY-2:0], core_halt_request};
		end
	end
	assign core_halt_ack = dly_q[ACK_DLY-1];
endmodule : dcs_core_model

// >>> tb/dcs_debug_ctrl_bench.sv
// Self-checking bench of the debug control and status block
`timescale 1ns/1ps
`include "dcs_defs.svh"
module dcs_debug_ctrl_bench;
	logic        sys_clk, rst_n, tck, trst_n, tdi, scan_sel, cap, shf, upd, idl, tdo;
	logic        hreq, cack, comb, creq, hack, gate, isa, mreq_n, fnd, dir, priv, hit;
	logic [31:0] addr, data, rv;
	logic [1:0]  size;
	int          n_errors, n_compared, cyc;

	dcs_debug_ctrl dcs_debug_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .tck(tck),
		.trst_n(trst_n), .tdi(tdi), .scan_sel(scan_sel), .tap_capture_dr(cap),
		.tap_shift_dr(shf), .tap_update_dr(upd), .tap_run_idle(idl), .tdo(tdo),
		.halt_request(hreq), .core_halt_ack(cack), .combined_halt_request_out(comb),
		.core_halt_request(creq), .halt_acknowledge(hack), .core_irq_gate(gate),
		.compact_isa_flag(isa), .core_memory_request_n(mreq_n), .core_addr(addr),
		.core_data(data), .fetch_not_data_bit(fnd), .direction_bit(dir),
		.access_size_field(size), .privileged_access_bit(priv), .breakpoint_hit(hit));
	dcs_core_model dcs_core_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.core_halt_request(creq), .core_halt_ack(cack));

	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;
	initial begin
		tck = 1'b0;
		#7;
		forever #32 tck = ~tck;
	end
	// Ceiling well above the roughly 3400 cycles the scans need
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic ws(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : ws

	// One DR scan; data bit 0 goes first, read/write bit last
	task automatic scan(input logic rw, input logic [4:0] a, input logic [31:0] d,
		input logic idle, output logic [31:0] q);
		logic [37:0] v;
		v = {rw, a, d};
		@(negedge tck);
		idl = 1'b0;
		scan_sel = 1'b1;
		cap = 1'b1;
		@(negedge tck);
		cap = 1'b0;
		shf = 1'b1;
		for (int i = 0; i < 38; i++) begin
			if (i < 32) q[i] = tdo;
			tdi = v[i];
			@(negedge tck);
		end
		shf = 1'b0;
		upd = 1'b1;
		@(negedge tck);
		upd = 1'b0;
		scan_sel = 1'b0;
		idl = idle;
	endtask : scan

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic idle);
		logic [31:0] q;
		scan(1'b1, a, d, idle, q);
		ws(8);
	endtask : wr

	// The address is taken at the first update, the word comes at the next capture
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		scan(1'b0, a, 32'h00000000, 1'b0, q);
		scan(1'b0, a, 32'h00000000, 1'b0, q);
		chk(q, exp);
	endtask : rd

	task automatic pins(input logic c, input logic h, input logic g);
		chk({29'h0, comb, hack, gate}, {29'h0, c, h, g});
		chk({31'h0, creq}, {31'h0, c});
	endtask : pins

	task automatic bus(input logic [31:0] a, input logic [31:0] d, input logic f,
		input logic w, input logic [1:0] s, input logic e);
		addr = a;
		data = d;
		fnd = f;
		dir = w;
		size = s;
		@(negedge sys_clk);
		@(negedge sys_clk);
		chk({31'h0, hit}, {31'h0, e});
	endtask : bus

	task automatic wp(input logic [31:0] av, am, dv, dm, input logic [8:0] cv,
		input logic [7:0] cm);
		wr(`DCS_ADDR_WP_AV, av, 1'b0);
		wr(`DCS_ADDR_WP_AM, am, 1'b0);
		wr(`DCS_ADDR_WP_DV, dv, 1'b0);
		wr(`DCS_ADDR_WP_DM, dm, 1'b0);
		wr(`DCS_ADDR_WP_CV, {23'h0, cv}, 1'b0);
		wr(`DCS_ADDR_WP_CM, {24'h0, cm}, 1'b0);
		ws(8);
	endtask : wp

	task automatic t_reset;
		rd(`DCS_ADDR_CTRL, 32'h00000000);
		pins(1'b0, 1'b0, 1'b1);
		chk({31'h0, hit}, 32'h00000000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_ctrl;
		wr(`DCS_ADDR_CTRL, 32'hfffffffa, 1'b0);
		rd(`DCS_ADDR_CTRL, 32'h00000002);
		ws(10);
		pins(1'b0, 1'b0, 1'b1);
		@(negedge tck);
		idl = 1'b1;
		repeat (2) @(negedge tck);
		idl = 1'b0;
		ws(10);
		pins(1'b1, 1'b1, 1'b0);
		rd(`DCS_ADDR_STATUS, 32'h0000000b);
		wr(`DCS_ADDR_STATUS, 32'h00000000, 1'b0);
		rd(`DCS_ADDR_STATUS, 32'h0000000b);
		wr(`DCS_ADDR_CTRL, 32'h00000000, 1'b1);
		pins(1'b0, 1'b0, 1'b1);
		wr(`DCS_ADDR_CTRL, 32'h00000001, 1'b1);
		pins(1'b0, 1'b1, 1'b0);
		wr(`DCS_ADDR_CTRL, 32'h00000004, 1'b1);
		pins(1'b0, 1'b0, 1'b0);
		isa = 1'b1;
		mreq_n = 1'b0;
		rd(`DCS_ADDR_STATUS, 32'h00000010);
		mreq_n = 1'b1;
		rd(`DCS_ADDR_STATUS, 32'h00000018);
		wr(`DCS_ADDR_CTRL, 32'h00000000, 1'b1);
		hreq = 1'b1;
		ws(10);
		pins(1'b1, 1'b1, 1'b0);
		rd(`DCS_ADDR_STATUS, 32'h0000001b);
		hreq = 1'b0;
		ws(10);
		rd(`DCS_ADDR_STATUS, 32'h0000001c);
		rd(5'h1f, 32'h00000000);
		$display("test control and status done");
	endtask : t_ctrl

	task automatic t_wp;
		logic [31:0] mem_word;
		logic [31:0] saved_word;
		wp(32'h0, 32'hffffffff, 32'hdeeedeee, 32'h0, 9'h100, 8'hf7);
		bus(32'h0, 32'h1234deee, 1'b0, 1'b0, 2'h2, 1'b1);
		bus(32'h2, 32'h1234deee, 1'b0, 1'b0, 2'h2, 1'b0);
		bus(32'h2, 32'hdeee0000, 1'b0, 1'b0, 2'h2, 1'b1);
		// Target word in memory: saved, replaced by the pattern, then put back
		mem_word = 32'h1234abcd;
		saved_word = mem_word;
		mem_word = 32'hdeeedeee;
		bus(32'h0, mem_word, 1'b0, 1'b0, 2'h2, 1'b1);
		mem_word = saved_word;
		bus(32'h0, mem_word, 1'b0, 1'b0, 2'h2, 1'b0);
		bus(32'h0, 32'h1234deee, 1'b1, 1'b0, 2'h2, 1'b0);
		isa = 1'b0;
		bus(32'h0, 32'h1234deee, 1'b0, 1'b0, 2'h2, 1'b0);
		wp(32'h200, 32'h3, 32'h0, 32'hffffffff, 9'h100, 8'hf7);
		bus(32'h203, 32'h5a5a5a5a, 1'b0, 1'b0, 2'h2, 1'b1);
		bus(32'h204, 32'h5a5a5a5a, 1'b0, 1'b0, 2'h2, 1'b0);
		wp(32'h100, 32'h0, 32'h0, 32'hffffffff, 9'h10d, 8'hf0);
		bus(32'h100, 32'h0, 1'b1, 1'b1, 2'h2, 1'b1);
		bus(32'h100, 32'h0, 1'b1, 1'b0, 2'h2, 1'b0);
		bus(32'h100, 32'h0, 1'b1, 1'b1, 2'h0, 1'b0);
		bus(32'h104, 32'h0, 1'b1, 1'b1, 2'h2, 1'b0);
		wr(`DCS_ADDR_WP_CM, 32'h000000f1, 1'b0);
		bus(32'h100, 32'h0, 1'b1, 1'b0, 2'h2, 1'b1);
		wr(`DCS_ADDR_WP_CV, 32'h0000000d, 1'b0);
		bus(32'h100, 32'h0, 1'b1, 1'b1, 2'h2, 1'b0);
		// Privileged bit compared in value and mask, direction left free
		wr(`DCS_ADDR_WP_CV, 32'h0000011d, 1'b0);
		wr(`DCS_ADDR_WP_CM, 32'h000000e1, 1'b0);
		priv = 1'b1;
		bus(32'h100, 32'h0, 1'b1, 1'b0, 2'h2, 1'b1);
		priv = 1'b0;
		bus(32'h100, 32'h0, 1'b1, 1'b0, 2'h2, 1'b0);
		$display("test comparator done");
	endtask : t_wp

	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	initial begin
		{rst_n, trst_n, tdi, scan_sel, cap, shf, upd, idl, hreq, isa, dir, priv} = '0;
		{mreq_n, fnd} = 2'b11;
		addr = 32'h0;
		data = 32'h0;
		size = 2'h0;
		n_errors = 0;
		n_compared = 0;
		cyc = 0;
		ws(4);
		rst_n = 1'b1;
		trst_n = 1'b1;
		ws(2);
		t_reset();
		t_ctrl();
		t_wp();
		summarize();
	end
endmodule : dcs_debug_ctrl_bench
